// ==== asuc_core.sv ====
`timescale 1ns/1ps
`include "asuc_defs.svh"
// Contract
// - Frame is start, 7 or 8 data, optional parity, 1 or 2 stop bits.
// - Even parity on transmit makes ones count of data plus parity even.
// - Even parity on receive flags error when ones count is odd.
// - Odd parity on transmit makes ones count of data plus parity odd.
// - Odd parity on receive flags error when ones count is even.
// - Zero parity sends 0 and never reports a parity error.
// - No parity omits the bit and never reports a parity error.
// - With transmit enabled, a data write starts a frame; the code drops writes while a frame is shifting.
// - Start, parity and stop bits are added by hardware.
// - Transmit-done pulses when the shift register empties.
// - Without new data after a frame the line stays idle high.
// - Clearing transmit enable aborts the frame at once.
// - After reset the shifter is empty and no done pulse occurs.
// - With receive enabled the input is sampled on the baud tick; in idle the code checks for a low input on every clock.
// - Low input starts count; still low at count m accepts start.
// - Completed frame goes to the buffer and receive-done pulses.
// - Errored frame still buffered; receive-done only if mask bit is 0.
// - Clearing receive enable stops reception silently, buffer unchanged.
// - Status holds parity, framing and overrun flags, 1 when occurred.
// - Flags clear on buffer read; new frame sets overrun and replaces the others with its own.
// - Framing error when stop is low; overrun when buffer still unread.
// - Any receive error also pulses receive-error.
module asuc_core (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd,
  output logic txd,
  output logic txDoneIrq,
  output logic rxDoneIrq,
  output logic rxErrorIrq
);
  asuc_pkg::asuc_mode_type mode, next_mode;
  logic [4:0] baudM, next_baudM;
  logic [3:0] baudTap, next_baudTap;
  logic awGot, next_awGot, wGot, next_wGot;
  logic [7:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wrTx, rdRx;
  logic [11:0] presc, next_presc, prescTop;
  logic refTick;
  asuc_pkg::asuc_txstate_type txState, next_txState;
  logic [11:0] txFrame, next_txFrame;
  logic [3:0] txIdx, next_txIdx, txLen, next_txLen;
  logic [4:0] txCnt, next_txCnt;
  logic next_txd, next_txDoneIrq;
  asuc_pkg::asuc_rxstate_type rxState, next_rxState;
  logic [4:0] rxCnt, next_rxCnt;
  logic [3:0] rxIdx, next_rxIdx;
  logic [9:0] rxBits, next_rxBits;
  logic [7:0] rxBuffer, next_rxBuffer;
  logic rxFull, next_rxFull;
  asuc_pkg::asuc_rxstat_type rxStatus, next_rxStatus;
  logic next_rxDoneIrq, next_rxErrorIrq;

  // Register slave; one write and one read in flight, answers one cycle after both halves
  always_comb begin
    logic doWrite;
    logic [31:0] rd;
    doWrite = awGot && wGot && !s_axi_bvalid;
    rd = 32'h0;
    next_mode = mode;
    next_baudM = baudM;
    next_baudTap = baudTap;
    next_awGot = awGot || (s_axi_awvalid && s_axi_awready);
    next_wGot = wGot || (s_axi_wvalid && s_axi_wready);
    next_awAddr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awAddr;
    next_wData = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wData;
    next_wStrb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wStrb;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    wrTx = 1'b0;
    if (doWrite) begin
      next_awGot = 1'b0;
      next_wGot = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `ASUC_RESP_OKAY;
      if (awAddr == `ASUC_OFS_MODE) begin
        if (wStrb[0]) next_mode = asuc_pkg::asuc_mode_type'(wData[7:0]);
      end else if (awAddr == `ASUC_OFS_TXDATA) begin
        wrTx = wStrb[0];
      end else if (awAddr == `ASUC_OFS_BAUD) begin
        if (wStrb[0]) next_baudM = wData[`ASUC_M_POS:0];
        if (wStrb[1]) next_baudTap = wData[`ASUC_TAP_POS:8];
      end else if (awAddr == `ASUC_OFS_STATUS || awAddr == `ASUC_OFS_RXDATA ||
                   awAddr == `ASUC_OFS_ENGINE) begin
        next_bresp = `ASUC_RESP_OKAY;
      end else begin
        next_bresp = `ASUC_RESP_SLVERR;
      end
    end
    next_awready = !next_awGot && !next_bvalid;
    next_wready = !next_wGot && !next_bvalid;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    rdRx = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `ASUC_RESP_OKAY;
      if (s_axi_araddr == `ASUC_OFS_MODE) begin
        rd = {24'h0, mode};
      end else if (s_axi_araddr == `ASUC_OFS_STATUS) begin
        rd = {29'h0, rxStatus};
      end else if (s_axi_araddr == `ASUC_OFS_TXDATA) begin
        rd = 32'h0;
      end else if (s_axi_araddr == `ASUC_OFS_RXDATA) begin
        rd = {24'h0, rxBuffer};
        rdRx = 1'b1;
      end else if (s_axi_araddr == `ASUC_OFS_BAUD) begin
        rd = {20'h0, baudTap, 3'h0, baudM};
      end else if (s_axi_araddr == `ASUC_OFS_ENGINE) begin
        rd = {29'h0, rxFull, rxState != asuc_pkg::RX_IDLE, txState == asuc_pkg::TX_SHIFT};
      end else begin
        next_rresp = `ASUC_RESP_SLVERR;
      end
      next_rdata = rd;
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode <= asuc_pkg::asuc_mode_type'(`ASUC_MODE_RESET);
      baudM <= `ASUC_M_RESET;
      baudTap <= `ASUC_TAP_RESET;
      awGot <= 1'b0;
      wGot <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      mode <= next_mode;
      baudM <= next_baudM;
      baudTap <= next_baudTap;
      awGot <= next_awGot;
      wGot <= next_wGot;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // Reference tick every 2^(n+1) clocks; taps above the top one clamp
  always_comb begin
    logic [3:0] tap;
    tap = (baudTap > `ASUC_TAP_MAX) ? `ASUC_TAP_MAX : baudTap;
    prescTop = 12'((13'h1 << (tap + 4'h1)) - 13'h1);
    refTick = (presc >= prescTop);
    next_presc = refTick ? 12'h0 : presc + 12'h1;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) presc <= 12'h0;
    else presc <= next_presc;
  end

  // Transmitter; writes while busy or disabled are dropped
  always_comb begin
    logic [7:0] d;
    logic pbit;
    next_txState = txState;
    next_txFrame = txFrame;
    next_txIdx = txIdx;
    next_txLen = txLen;
    next_txCnt = txCnt;
    next_txd = txd;
    next_txDoneIrq = 1'b0;
    d = mode.charLen8 ? wData[7:0] : {1'b0, wData[6:0]};
    pbit = 1'b0;
    if (mode.parity == `ASUC_PAR_EVEN) pbit = ^d;
    else if (mode.parity == `ASUC_PAR_ODD) pbit = ~^d;
    case (txState)
      asuc_pkg::TX_IDLE: begin
        next_txd = 1'b1;
        if (wrTx && mode.txEnableBit) begin
          next_txFrame = 12'hfff;
          next_txFrame[0] = 1'b0;
          if (mode.charLen8) next_txFrame[8:1] = d;
          else next_txFrame[7:1] = d[6:0];
          if (mode.parity != `ASUC_PAR_NONE) begin
            if (mode.charLen8) next_txFrame[9] = pbit;
            else next_txFrame[8] = pbit;
          end
          next_txLen = 4'd8 + {3'h0, mode.charLen8} +
                       {3'h0, mode.parity != `ASUC_PAR_NONE} + {3'h0, mode.stopLen2};
          next_txIdx = 4'h0;
          next_txCnt = 5'h0;
          next_txd = 1'b0;
          next_txState = asuc_pkg::TX_SHIFT;
        end
      end
      asuc_pkg::TX_SHIFT: begin
        if (!mode.txEnableBit) begin
          next_txState = asuc_pkg::TX_IDLE;
          next_txd = 1'b1;
        end else if (refTick) begin
          if (txCnt == baudM - 5'h1) begin
            next_txCnt = 5'h0;
            if (txIdx == txLen) begin
              next_txState = asuc_pkg::TX_IDLE;
              next_txd = 1'b1;
              next_txDoneIrq = 1'b1;
            end else begin
              next_txIdx = txIdx + 4'h1;
              next_txFrame = {1'b1, txFrame[11:1]};
              next_txd = txFrame[1];
            end
          end else begin
            next_txCnt = txCnt + 5'h1;
          end
        end
      end
      default: next_txState = asuc_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      txState <= asuc_pkg::TX_IDLE;
      txFrame <= 12'hfff;
      txIdx <= 4'h0;
      txLen <= 4'h0;
      txCnt <= 5'h0;
      txd <= 1'b1;
      txDoneIrq <= 1'b0;
    end else begin
      txState <= next_txState;
      txFrame <= next_txFrame;
      txIdx <= next_txIdx;
      txLen <= next_txLen;
      txCnt <= next_txCnt;
      txd <= next_txd;
      txDoneIrq <= next_txDoneIrq;
    end
  end

  // Receiver; a frame ending in the cycle of a buffer read wins over the read
  always_comb begin
    logic [3:0] lastIdx;
    logic [7:0] d;
    logic p, pe, fe, rx_lost_data_flag;
    lastIdx = 4'd7 + {3'h0, mode.charLen8} + {3'h0, mode.parity != `ASUC_PAR_NONE};
    d = mode.charLen8 ? rxBits[7:0] : {1'b0, rxBits[6:0]};
    p = mode.charLen8 ? rxBits[8] : rxBits[7];
    pe = 1'b0;
    if (mode.parity == `ASUC_PAR_EVEN) pe = ^{d, p};
    else if (mode.parity == `ASUC_PAR_ODD) pe = ~^{d, p};
    fe = !rxd;
    rx_lost_data_flag = rxFull && !rdRx;
    next_rxState = rxState;
    next_rxCnt = rxCnt;
    next_rxIdx = rxIdx;
    next_rxBits = rxBits;
    next_rxBuffer = rxBuffer;
    next_rxFull = rxFull;
    next_rxStatus = rxStatus;
    next_rxDoneIrq = 1'b0;
    next_rxErrorIrq = 1'b0;
    if (rdRx) begin
      next_rxFull = 1'b0;
      next_rxStatus = '0;
    end
    case (rxState)
      asuc_pkg::RX_IDLE: begin
        next_rxCnt = 5'h0;
        if (mode.rxEnableBit && !rxd) next_rxState = asuc_pkg::RX_START;
      end
      asuc_pkg::RX_START: begin
        if (!mode.rxEnableBit) begin
          next_rxState = asuc_pkg::RX_IDLE;
        end else if (refTick) begin
          if (rxCnt == baudM - 5'h1) begin
            next_rxCnt = 5'h0;
            next_rxIdx = 4'h0;
            next_rxState = rxd ? asuc_pkg::RX_IDLE : asuc_pkg::RX_BITS;
          end else begin
            next_rxCnt = rxCnt + 5'h1;
          end
        end
      end
      asuc_pkg::RX_BITS: begin
        if (!mode.rxEnableBit) begin
          next_rxState = asuc_pkg::RX_IDLE;
        end else if (refTick) begin
          if (rxCnt == baudM - 5'h1) begin
            next_rxCnt = 5'h0;
            if (rxIdx == lastIdx) begin
              next_rxState = asuc_pkg::RX_IDLE;
              next_rxBuffer = d;
              next_rxFull = 1'b1;
              next_rxStatus = {pe, fe, rx_lost_data_flag};
              next_rxErrorIrq = pe || fe || rx_lost_data_flag;
              next_rxDoneIrq = !(pe || fe || rx_lost_data_flag) || !mode.errRxIrqMask;
            end else begin
              next_rxBits[rxIdx] = rxd;
              next_rxIdx = rxIdx + 4'h1;
            end
          end else begin
            next_rxCnt = rxCnt + 5'h1;
          end
        end
      end
      default: next_rxState = asuc_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rxState <= asuc_pkg::RX_IDLE;
      rxCnt <= 5'h0;
      rxIdx <= 4'h0;
      rxBits <= 10'h0;
      rxBuffer <= 8'h00;
      rxFull <= 1'b0;
      rxStatus <= '0;
      rxDoneIrq <= 1'b0;
      rxErrorIrq <= 1'b0;
    end else begin
      rxState <= next_rxState;
      rxCnt <= next_rxCnt;
      rxIdx <= next_rxIdx;
      rxBits <= next_rxBits;
      rxBuffer <= next_rxBuffer;
      rxFull <= next_rxFull;
      rxStatus <= next_rxStatus;
      rxDoneIrq <= next_rxDoneIrq;
      rxErrorIrq <= next_rxErrorIrq;
    end
  end

  a_tx_idle_line: assert property (@(posedge clk_sys) disable iff (reset)
    (txState == asuc_pkg::TX_IDLE) |-> txd) else $error("line not idle high");
  a_tx_start_bit: assert property (@(posedge clk_sys) disable iff (reset)
    (txState == asuc_pkg::TX_IDLE && wrTx && mode.txEnableBit) |=> !txd [*2])
    else $error("start bit missing");
  a_tx_abort_now: assert property (@(posedge clk_sys) disable iff (reset)
    (txState == asuc_pkg::TX_SHIFT && !mode.txEnableBit) |=>
      (txState == asuc_pkg::TX_IDLE && txd && !txDoneIrq)) else $error("abort too slow");
  a_tx_done_idle: assert property (@(posedge clk_sys) disable iff (reset)
    txDoneIrq |-> ($past(txState) == asuc_pkg::TX_SHIFT && txState == asuc_pkg::TX_IDLE))
    else $error("done without frame");
  a_rx_abort_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    (rxState != asuc_pkg::RX_IDLE && !mode.rxEnableBit) |=>
      (!rxDoneIrq && !rxErrorIrq && $stable(rxBuffer))) else $error("abort not silent");
  a_rx_err_flag: assert property (@(posedge clk_sys) disable iff (reset)
    rxErrorIrq |-> (rxStatus != '0 && rxFull)) else $error("error pulse without flag");
  a_rx_mask_done: assert property (@(posedge clk_sys) disable iff (reset)
    (rxErrorIrq && $past(mode.errRxIrqMask)) |-> !rxDoneIrq) else $error("masked done fired");
  a_rx_par_mode: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(rxStatus.parityErrFlag) |-> $past(mode.parity[1])) else $error("parity not checked");
  a_rx_read_clear: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(rxFull) |-> (rxStatus == '0)) else $error("flags survive read");
  a_rx_overrun: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(rxStatus.rxLostDataFlag) |-> $past(rxFull)) else $error("overrun without full");
endmodule

// ==== asuc_defs.svh ====
`ifndef ASUC_DEFS_SVH
`define ASUC_DEFS_SVH
`define ASUC_OFS_MODE 8'h00
`define ASUC_OFS_STATUS 8'h04
`define ASUC_OFS_TXDATA 8'h08
`define ASUC_OFS_RXDATA 8'h0c
`define ASUC_OFS_BAUD 8'h10
`define ASUC_OFS_ENGINE 8'h14
`define ASUC_MODE_RESET 8'h00
`define ASUC_M_RESET 5'h10
`define ASUC_TAP_RESET 4'h0
`define ASUC_TAP_MAX 4'hb
`define ASUC_M_POS 4
`define ASUC_TAP_POS 11
`define ASUC_PAR_NONE 2'h0
`define ASUC_PAR_ZERO 2'h1
`define ASUC_PAR_ODD 2'h2
`define ASUC_PAR_EVEN 2'h3
`define ASUC_RESP_OKAY 2'h0
`define ASUC_RESP_SLVERR 2'h2
`endif

// ==== asuc_pkg.sv ====
package asuc_pkg;
  typedef struct packed {
    logic txEnableBit;
    logic rxEnableBit;
    logic [1:0] parity;
    logic charLen8;
    logic stopLen2;
    logic errRxIrqMask;
    logic clkSel;
  } asuc_mode_type;
  typedef struct packed {
    logic parityErrFlag;
    logic framingErrFlag;
    logic rxLostDataFlag;
  } asuc_rxstat_type;
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} asuc_txstate_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asuc_rxstate_type;
endpackage

// ==== asuc_remote_node.sv ====
`timescale 1ns/1ps
module asuc_remote_node #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_sys,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  // Start stretched half a bit: the core resamples on bit boundaries,
  // so every later sample then lands mid-bit whatever the tick phase
  task automatic send_frame(input logic [7:0] d, input int nb, input logic hasPar,
      input logic parBit, input logic stopVal);
    rxd <= 1'b0;
    repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    if (hasPar) begin
      rxd <= parBit;
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    rxd <= stopVal;
    repeat (BIT_CLKS) @(posedge clk_sys);
    rxd <= 1'b1;
  endtask
  // Twelve mid-bit samples cover the longest frame; idle slots read high
  task automatic get_frame(output logic [11:0] v, output logic ok);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    ok = (n < 4000);
    repeat (BIT_CLKS / 2) @(posedge clk_sys);
    for (int k = 0; k < 12; k++) begin
      v[k] = txd;
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
  endtask
endmodule

// ==== tb_async_serial_uart_core.sv ====
`timescale 1ns/1ps
`include "asuc_defs.svh"
module tb_async_serial_uart_core;
  localparam int B = 32;
  localparam int LIM = 5000;
  logic clk_sys, reset, rxd, txd, txDoneIrq, rxDoneIrq, rxErrorIrq, prevTxd, ok, s2, inFrame;
  logic [7:0] s_axi_awaddr, s_axi_araddr, d;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] lfsr;
  logic [11:0] v;
  int num_errors, cmp_count, nTxDone, nRxDone, nRxErr, nFall, sinceFall, lastLen;
  int nb, k, e, f, ln;
  int tPm[4] = '{2, 3, 1, 0};
  int tFlip[4] = '{1, 1, 1, 0};
  int tStop[4] = '{1, 1, 1, 0};
  int tMask[4] = '{0, 1, 0, 1};
  int tStat[4] = '{4, 4, 0, 2};
  asuc_core dut (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .txDoneIrq, .rxDoneIrq,
    .rxErrorIrq);
  asuc_remote_node #(.BIT_CLKS(B)) partner (.clk_sys, .txd, .rxd);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Pulses are counted here so no one-cycle event slips between checks
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      nTxDone <= 0;
      nRxDone <= 0;
      nRxErr <= 0;
      nFall <= 0;
      sinceFall <= 0;
      prevTxd <= 1'b1;
      inFrame <= 1'b0;
    end else begin
      nTxDone <= nTxDone + int'(txDoneIrq === 1'b1);
      nRxDone <= nRxDone + int'(rxDoneIrq === 1'b1);
      nRxErr <= nRxErr + int'(rxErrorIrq === 1'b1);
      prevTxd <= txd;
      // Only the start bit restarts the length count, not falls inside the frame
      sinceFall <= (!inFrame && prevTxd === 1'b1 && txd === 1'b0) ? 1 : sinceFall + 1;
      if (prevTxd === 1'b1 && txd === 1'b0) nFall <= nFall + 1;
      if (!inFrame && prevTxd === 1'b1 && txd === 1'b0) inFrame <= 1'b1;
      if (txDoneIrq === 1'b1) begin
        lastLen <= sinceFall;
        inFrame <= 1'b0;
      end
    end
  end
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] md(input logic tx, rx, input logic [1:0] pm,
      input logic c8, st2, mk);
    asuc_pkg::asuc_mode_type m;
    m = '{tx, rx, pm, c8, st2, mk, 1'b1};
    return m;
  endfunction
  function automatic logic exp_par(input logic [7:0] dd, input int n, input int pm);
    logic x;
    x = (n == 8) ? ^dd : ^dd[6:0];
    return (pm == `ASUC_PAR_EVEN) ? x : (pm == `ASUC_PAR_ODD) ? ~x : 1'b0;
  endfunction
  function automatic logic [11:0] exp_frame(input logic [7:0] dd, input int n, input int pm);
    logic [11:0] r;
    r = 12'hfff;
    r[0] = 1'b0;
    for (int i = 0; i < n; i++) r[i + 1] = dd[i];
    if (pm != `ASUC_PAR_NONE) r[n + 1] = exp_par(dd, n, pm);
    return r;
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic guard(inout int n);
    n++;
    if (n > LIM) begin
      num_errors++;
      $display("[FAIL] handshake expected within limit seen none");
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dd, input logic [1:0] er);
    logic aw, w;
    int n;
    aw = 1'b0;
    w = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, dd};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      guard(n);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk_sys);
      guard(n);
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rdck(input string nm, input logic [7:0] a, input logic [7:0] ex,
      input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      guard(n);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clk_sys);
      guard(n);
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check("rresp", 32'(s_axi_rresp), 32'(er));
    check(nm, s_axi_rdata, {24'h000000, ex});
  endtask
  task automatic send(input int pm, input logic fl, input logic st);
    partner.send_frame(d, nb, pm != 0, exp_par(d, nb, pm) ^ fl, st);
    repeat (4) @(posedge clk_sys);
    // A low stop bit looks like a new start; let that attempt expire
    if (!st) repeat (2 * B) @(posedge clk_sys);
  endtask
  initial begin
    lfsr = 16'h004d;
    num_errors = 0;
    cmp_count = 0;
    reset = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rdck("status", `ASUC_OFS_STATUS, 8'h00, `ASUC_RESP_OKAY);
    rdck("unmapped", 8'h18, 8'h00, `ASUC_RESP_SLVERR);
    wr(8'h18, 8'h5a, `ASUC_RESP_SLVERR);
    wr(`ASUC_OFS_STATUS, 8'hff, `ASUC_RESP_OKAY);
    rdck("status ro", `ASUC_OFS_STATUS, 8'h00, `ASUC_RESP_OKAY);
    rdck("mode", `ASUC_OFS_MODE, `ASUC_MODE_RESET, `ASUC_RESP_OKAY);
    rdck("engine", `ASUC_OFS_ENGINE, 8'h00, `ASUC_RESP_OKAY);
    wr(`ASUC_OFS_BAUD, 8'h10, `ASUC_RESP_OKAY);
    rdck("baud", `ASUC_OFS_BAUD, 8'h10, `ASUC_RESP_OKAY);
    check("done after reset", nTxDone, 0);
    $display("test reset done");
    for (int pm = 0; pm < 4; pm++) begin
      for (int c8 = 0; c8 < 2; c8++) begin
        lfsr = lfsr_step(lfsr);
        d = lfsr[7:0];
        s2 = lfsr[9];
        nb = c8 ? 8 : 7;
        wr(`ASUC_OFS_MODE, md(1, 0, 2'(pm), c8[0], s2, 0), `ASUC_RESP_OKAY);
        k = nTxDone;
        fork
          partner.get_frame(v, ok);
          wr(`ASUC_OFS_TXDATA, d, `ASUC_RESP_OKAY);
        join
        ln = (2 + nb + int'(pm != 0) + s2) * B;
        check("tx start", 32'(ok), 1);
        check("tx frame", 32'(v), 32'(exp_frame(d, nb, pm)));
        check("tx done", nTxDone, k + 1);
        check("tx len", 32'(lastLen >= ln - 4 && lastLen <= ln + 2), 1);
      end
    end
    $display("test transmit done");
    wr(`ASUC_OFS_TXDATA, 8'h00, `ASUC_RESP_OKAY);
    repeat (3 * B) @(posedge clk_sys);
    rdck("tx busy", `ASUC_OFS_ENGINE, 8'h01, `ASUC_RESP_OKAY);
    k = nTxDone;
    wr(`ASUC_OFS_MODE, md(0, 0, 0, 1, 0, 0), `ASUC_RESP_OKAY);
    // Abort lands on the edge that the response is seen on
    @(posedge clk_sys);
    check("abort idle", 32'(txd), 1);
    f = nFall;
    wr(`ASUC_OFS_TXDATA, 8'h00, `ASUC_RESP_OKAY);
    repeat (12 * B) @(posedge clk_sys);
    check("abort falls", nFall, f);
    check("abort done", nTxDone, k);
    $display("test abort done");
    for (int pm = 0; pm < 4; pm++) begin
      for (int c8 = 0; c8 < 2; c8++) begin
        lfsr = lfsr_step(lfsr);
        d = lfsr[7:0];
        nb = c8 ? 8 : 7;
        wr(`ASUC_OFS_MODE, md(0, 1, 2'(pm), c8[0], 0, 0), `ASUC_RESP_OKAY);
        k = nRxDone;
        e = nRxErr;
        send(pm, 0, 1);
        check("rx done", nRxDone, k + 1);
        check("rx err", nRxErr, e);
        rdck("rx status", `ASUC_OFS_STATUS, 8'h00, `ASUC_RESP_OKAY);
        rdck("rx data", `ASUC_OFS_RXDATA, c8 ? d : {1'b0, d[6:0]}, `ASUC_RESP_OKAY);
      end
    end
    $display("test receive done");
    for (int t = 0; t < 4; t++) begin
      lfsr = lfsr_step(lfsr);
      d = lfsr[7:0];
      nb = 8;
      wr(`ASUC_OFS_MODE, md(0, 1, 2'(tPm[t]), 1, 0, tMask[t][0]), `ASUC_RESP_OKAY);
      k = nRxDone;
      e = nRxErr;
      send(tPm[t], tFlip[t][0], tStop[t][0]);
      check("err irq", nRxErr, e + int'(tStat[t] != 0));
      check("err done", nRxDone, k + int'(tMask[t] == 0 || tStat[t] == 0));
      rdck("err status", `ASUC_OFS_STATUS, 8'(tStat[t]), `ASUC_RESP_OKAY);
      rdck("err data", `ASUC_OFS_RXDATA, d, `ASUC_RESP_OKAY);
      rdck("err clear", `ASUC_OFS_STATUS, 8'h00, `ASUC_RESP_OKAY);
    end
    $display("test errors done");
    wr(`ASUC_OFS_MODE, md(0, 1, `ASUC_PAR_EVEN, 1, 0, 0), `ASUC_RESP_OKAY);
    e = nRxErr;
    d = 8'h3c;
    send(`ASUC_PAR_EVEN, 1, 1);
    d = 8'hc5;
    send(`ASUC_PAR_EVEN, 0, 1);
    check("ovr irq", nRxErr, e + 2);
    rdck("ovr status", `ASUC_OFS_STATUS, 8'h01, `ASUC_RESP_OKAY);
    rdck("ovr data", `ASUC_OFS_RXDATA, 8'hc5, `ASUC_RESP_OKAY);
    rdck("ovr clear", `ASUC_OFS_STATUS, 8'h00, `ASUC_RESP_OKAY);
    $display("test overrun done");
    wr(`ASUC_OFS_MODE, md(0, 1, 0, 1, 0, 0), `ASUC_RESP_OKAY);
    k = nRxDone;
    e = nRxErr;
    d = 8'h00;
    fork
      send(`ASUC_PAR_NONE, 0, 0);
      begin
        repeat (4 * B) @(posedge clk_sys);
        wr(`ASUC_OFS_MODE, md(0, 0, 0, 1, 0, 0), `ASUC_RESP_OKAY);
      end
    join
    send(`ASUC_PAR_NONE, 0, 1);
    check("rx stop done", nRxDone, k);
    check("rx stop err", nRxErr, e);
    rdck("rx stop data", `ASUC_OFS_RXDATA, 8'hc5, `ASUC_RESP_OKAY);
    rdck("rx stop status", `ASUC_OFS_STATUS, 8'h00, `ASUC_RESP_OKAY);
    $display("test receive stop done");
    wrap_up();
  end
endmodule
